// File: hdl/mpd_port.sv
/*
  Multicore pin direction port top: APB slave, per-core direction
  registers, wired-OR of active cores and per-pin output enables.
  Assumes a single APB master on pclk and synchronous pin inputs.
*/
// Design decisions made here: the APB register port and the register addresses.
// Notes on behaviour
// [R1] Each core direction register is 32 bits.
// [R2] Bit zero is input, one is output.
// [R3] Core start clears its direction register.
// [R4] Effective direction is OR of cores.
// [R5] Disabled core contributes all zeros.
// [R6] Every core reaches its register without arbitration.
// [R7] Single-bit write changes only that bit.
// [R8] Range write: lsb goes to end index.
// [R9] Reads place bits low, upper bits zero.
// [R10] Upper port direction register is reserved.
// [R11] Core drives pin only when direction set.
// [R12] Combined direction updates cycle after write.
`timescale 1ns/1ps
module mpd_port
  import mpd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core start pulses
  input wire logic [NUM_CORES-1:0] core_start,
  // Pins
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } mpd_state_e;

  mpd_state_e state_q;
  mpd_apb_req_s req;
  logic [NUM_CORES-1:0] core_en_q;
  mpd_range_s range_q;
  logic [NUM_PINS-1:0] dir_q [NUM_CORES];
  logic [NUM_PINS-1:0] out_q [NUM_CORES];
  logic [NUM_PINS-1:0] eff_dir_d;
  logic [NUM_PINS-1:0] pin_out_d;
  logic [NUM_PINS-1:0] wmask;
  logic [NUM_PINS-1:0] wbits;
  logic [31:0] range_rval;
  logic [CORE_IDX_W-1:0] core_sel;
  logic [ADDR_W-1:0] core_off;
  logic in_core_win;
  logic access;
  logic [31:0] rdata_d;
  logic err_d;

  // Core windows sit below the shared registers.
  function automatic logic is_core_win(input logic [ADDR_W-1:0] a);
    return a < (CORE_STRIDE * 12'(NUM_CORES));
  endfunction : is_core_win

  function automatic logic [ADDR_W-1:0] win_off(input logic [ADDR_W-1:0] a);
    return a & (CORE_STRIDE - 12'h001);
  endfunction : win_off

  // Pins covered by a range, whichever way round its ends are given.
  function automatic logic [NUM_PINS-1:0] span_mask(input mpd_range_s r);
    logic [PIN_IDX_W-1:0] lo;
    logic [PIN_IDX_W-1:0] hi;
    lo = (r.start_idx < r.end_idx) ? r.start_idx : r.end_idx;
    hi = (r.start_idx < r.end_idx) ? r.end_idx : r.start_idx;
    return ({NUM_PINS{1'b1}} << lo) & ({NUM_PINS{1'b1}} >> (PIN_IDX_W'(NUM_PINS - 1) - hi));
  endfunction : span_mask

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  assign access = req.sel && req.enable && (state_q == ST_IDLE);
  assign in_core_win = is_core_win(req.addr);
  assign core_sel = CORE_IDX_W'(req.addr >> 4);
  assign core_off = win_off(req.addr);

  mpd_range_unit u_range (
    .rng(range_q),
    .wval(req.wdata),
    .cur(dir_q[core_sel]),
    .wmask(wmask),
    .wbits(wbits),
    .rval(range_rval)
  );

  // Each core has its own register and strobes, so no access waits on another core.
  for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
    logic hit;
    assign hit = access && req.write && in_core_win && (core_sel == CORE_IDX_W'(c)); // [R6]
    mpd_core_dir u_dir (
      .pclk(pclk),
      .presetn(presetn),
      .core_start(core_start[c]),
      .wr_whole(hit && core_off == OFF_DIR_WHOLE && pstrb == 4'hf),
      .wr_masked(hit && core_off == OFF_DIR_RANGE),
      .wmask(wmask),
      .wbits(wbits),
      .wdata(req.wdata),
      .dir_q(dir_q[c])
    );

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_q[c] <= DIR_RESET;
      end else if (hit && core_off == OFF_OUT_DATA) begin
        out_q[c] <= req.wdata;
      end
    end

    property p_start_clears_core;
      @(posedge pclk) disable iff (!presetn)
        core_start[c] |=> dir_q[c] == DIR_RESET;
    endproperty
    a_start_clears_core: assert property (p_start_clears_core) else $error("start did not clear"); // [R3]

    property p_other_core_untouched;
      @(posedge pclk) disable iff (!presetn)
        (!hit && !core_start[c]) |=> $stable(dir_q[c]);
    endproperty
    a_other_core_untouched: assert property (p_other_core_untouched) else $error("direction moved unasked"); // [R6]

    property p_lone_core_sets_pins;
      @(posedge pclk) disable iff (!presetn)
        (core_en_q == NUM_CORES'(1 << c)) |=> pin_oe == $past(dir_q[c]);
    endproperty
    a_lone_core_sets_pins: assert property (p_lone_core_sets_pins) else $error("lone core mismatch"); // [R5]
  end

  // Wired-OR over active cores; a disabled core's bits are masked off.
  always_comb begin
    eff_dir_d = '0;
    pin_out_d = '0;
    for (int c = 0; c < NUM_CORES; c++) begin
      if (core_en_q[c]) begin
        eff_dir_d = eff_dir_d | dir_q[c]; // [R4] [R5]
        pin_out_d = pin_out_d | (out_q[c] & dir_q[c]); // [R11]
      end
    end
  end

  // A one bit is an output: it raises that pin's enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe <= DIR_RESET;
      pin_out <= DIR_RESET;
    end else begin
      pin_oe <= eff_dir_d; // [R2] [R12]
      pin_out <= pin_out_d; // [R11]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_en_q <= CORE_EN_RESET;
    end else if (access && req.write && req.addr == OFF_CORE_EN) begin
      core_en_q <= req.wdata[NUM_CORES-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_q <= '0;
    end else if (access && req.write && req.addr == OFF_RANGE_SEL) begin
      range_q.start_idx <= req.wdata[RSEL_START_LSB +: PIN_IDX_W];
      range_q.end_idx <= req.wdata[RSEL_END_LSB +: PIN_IDX_W];
    end
  end

  // Read mux and error decode.
  always_comb begin
    rdata_d = '0;
    err_d = 1'b0;
    if (in_core_win) begin
      case (core_off)
        OFF_DIR_WHOLE: rdata_d = dir_q[core_sel]; // [R9]
        OFF_DIR_RANGE: rdata_d = range_rval; // [R9]
        OFF_UPPER_DIR: rdata_d = RESERVED_READ; // [R10]
        OFF_OUT_DATA: rdata_d = out_q[core_sel];
        default: err_d = 1'b1;
      endcase
    end else begin
      case (req.addr)
        OFF_CORE_EN: rdata_d = {{(32-NUM_CORES){1'b0}}, core_en_q};
        OFF_EFF_DIR: rdata_d = eff_dir_d;
        OFF_RANGE_SEL: rdata_d = {19'h0, range_q.end_idx, 3'h0, range_q.start_idx};
        default: err_d = 1'b1;
      endcase
    end
    if (req.write && !in_core_win && req.addr == OFF_EFF_DIR) begin
      err_d = 1'b1;
    end
  end

  // Every transfer answers in its second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          pready <= access;
          pslverr <= access && err_d;
          prdata <= (access && !req.write) ? rdata_d : 32'h0000_0000;
          if (access) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          pready <= 1'b0;
          pslverr <= 1'b0;
          prdata <= '0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  property p_oe_follows_or;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> pin_oe == $past((dir_q[0] & {NUM_PINS{core_en_q[0]}}) | (dir_q[1] & {NUM_PINS{core_en_q[1]}}) |
        (dir_q[2] & {NUM_PINS{core_en_q[2]}}) | (dir_q[3] & {NUM_PINS{core_en_q[3]}}));
  endproperty
  a_oe_follows_or: assert property (p_oe_follows_or) else $error("pin enable not the OR of cores"); // [R4] [R12]

  property p_disabled_core_silent;
    @(posedge pclk) disable iff (!presetn)
      (core_en_q == 4'h0) |=> pin_oe == 32'h0000_0000;
  endproperty
  a_disabled_core_silent: assert property (p_disabled_core_silent) else $error("disabled cores drive a direction"); // [R5]

  property p_start_clears;
    @(posedge pclk) disable iff (!presetn)
      core_start[0] |=> dir_q[0] == 32'h0000_0000;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("core start did not clear direction"); // [R3]

  property p_out_gated;
    @(posedge pclk) disable iff (!presetn)
      (pin_out & ~pin_oe) == 32'h0000_0000;
  endproperty
  a_out_gated: assert property (p_out_gated) else $error("pin driven without direction set"); // [R11]

  sequence s_bit_write;
    access && req.write && in_core_win && core_off == OFF_DIR_RANGE && !core_start[core_sel];
  endsequence

  property p_range_only;
    @(posedge pclk) disable iff (!presetn)
      s_bit_write |=> ((dir_q[$past(core_sel)] ^ $past(dir_q[core_sel])) & ~$past(span_mask(range_q))) == 32'h0;
  endproperty
  a_range_only: assert property (p_range_only) else $error("bits outside range changed"); // [R7] [R8]

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
      (access && !req.write && in_core_win && core_off == OFF_UPPER_DIR) |=> prdata == 32'h0 && pready;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved register read nonzero"); // [R10]

  property p_read_whole;
    @(posedge pclk) disable iff (!presetn)
      (access && !req.write && in_core_win && core_off == OFF_DIR_WHOLE) |=> prdata == $past(dir_q[core_sel]);
  endproperty
  a_read_whole: assert property (p_read_whole) else $error("direction read mismatch"); // [R9]

  property p_no_wait;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable) |-> ##[0:1] pready;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("access waited beyond one cycle"); // [R6]

  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("answer held past one cycle"); // [R6]

  property p_pin_out_or;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> pin_out == $past((out_q[0] & dir_q[0] & {NUM_PINS{core_en_q[0]}}) |
        (out_q[1] & dir_q[1] & {NUM_PINS{core_en_q[1]}}) | (out_q[2] & dir_q[2] & {NUM_PINS{core_en_q[2]}}) |
        (out_q[3] & dir_q[3] & {NUM_PINS{core_en_q[3]}}));
  endproperty
  a_pin_out_or: assert property (p_pin_out_or) else $error("pin output not the gated OR"); // [R11]

  sequence s_whole_write;
    access && req.write && in_core_win && core_off == OFF_DIR_WHOLE && pstrb == 4'hf && !core_start[core_sel];
  endsequence

  property p_whole_write;
    @(posedge pclk) disable iff (!presetn)
      s_whole_write |=> dir_q[$past(core_sel)] == $past(req.wdata);
  endproperty
  a_whole_write: assert property (p_whole_write) else $error("whole write not stored"); // [R1]

  property p_range_lsb_end;
    @(posedge pclk) disable iff (!presetn)
      s_bit_write |=> dir_q[$past(core_sel)][$past(range_q.end_idx)] == $past(req.wdata[0]);
  endproperty
  a_range_lsb_end: assert property (p_range_lsb_end) else $error("range low bit misplaced"); // [R8]

  property p_range_msb_start;
    @(posedge pclk) disable iff (!presetn)
      s_bit_write |=> dir_q[$past(core_sel)][$past(range_q.start_idx)] ==
        $past(req.wdata[$countones(span_mask(range_q)) - 1]);
  endproperty
  a_range_msb_start: assert property (p_range_msb_start) else $error("range top bit misplaced"); // [R8]

  sequence s_range_read;
    access && !req.write && in_core_win && core_off == OFF_DIR_RANGE;
  endsequence

  property p_range_read_low;
    @(posedge pclk) disable iff (!presetn)
      s_range_read |=> prdata[0] == $past(dir_q[core_sel][range_q.end_idx]) &&
        (prdata >> $countones($past(span_mask(range_q)))) == 32'h0;
  endproperty
  a_range_read_low: assert property (p_range_read_low) else $error("range read misplaced"); // [R9]

  property p_upper_write_ignored;
    @(posedge pclk) disable iff (!presetn)
      (access && req.write && in_core_win && core_off == OFF_UPPER_DIR && !core_start[core_sel])
        |=> dir_q[$past(core_sel)] == $past(dir_q[core_sel]) && !pslverr;
  endproperty
  a_upper_write_ignored: assert property (p_upper_write_ignored) else $error("reserved write had effect"); // [R10]

  property p_eff_read;
    @(posedge pclk) disable iff (!presetn)
      (access && !req.write && !in_core_win && req.addr == OFF_EFF_DIR) |=> prdata == pin_oe;
  endproperty
  a_eff_read: assert property (p_eff_read) else $error("combined read differs from pins"); // [R4]
endmodule : mpd_port

// File: hdl/mpd_pkg.sv
/*
  Package for the multicore pin direction port: register map, field layout,
  reset values and the bus and range carriers.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package mpd_pkg;
  localparam int NUM_CORES = 4;
  localparam int CORE_IDX_W = 2;
  localparam int NUM_PINS = 32;
  localparam int PIN_IDX_W = 5;
  localparam int ADDR_W = 12;

  // Register windows: each core owns a block of four words.
  localparam logic [ADDR_W-1:0] CORE_STRIDE = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_DIR_WHOLE = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_DIR_RANGE = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_UPPER_DIR = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_OUT_DATA = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_CORE_EN = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_EFF_DIR = 12'h104;
  localparam logic [ADDR_W-1:0] OFF_RANGE_SEL = 12'h108;

  // Range select register fields: start index, end index.
  localparam int RSEL_START_LSB = 0;
  localparam int RSEL_END_LSB = 8;

  localparam logic [NUM_PINS-1:0] DIR_RESET = 32'h0000_0000;
  localparam logic [NUM_CORES-1:0] CORE_EN_RESET = 4'h0;
  localparam logic [31:0] RESERVED_READ = 32'h0000_0000;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } mpd_apb_req_s;

  typedef struct packed {
    logic [PIN_IDX_W-1:0] start_idx;
    logic [PIN_IDX_W-1:0] end_idx;
  } mpd_range_s;
endpackage : mpd_pkg

// File: hdl/mpd_range_unit.sv
/*
  Range access helper: builds the mask and placed data for a write to a
  contiguous bit range, and extracts a range for reading.
  Assumes the indices are already within 0 to 31.
*/
`timescale 1ns/1ps
module mpd_range_unit
  import mpd_pkg::*;
(
  // Range and data
  input wire mpd_range_s rng,
  input wire logic [31:0] wval,
  input wire logic [NUM_PINS-1:0] cur,
  // Results
  output logic [NUM_PINS-1:0] wmask,
  output logic [NUM_PINS-1:0] wbits,
  output logic [31:0] rval
);
  // The value's lsb lands on the end index; higher bits walk toward start.
  always_comb begin
    int lo;
    int hi;
    int k;
    lo = 0;
    hi = 0;
    k = 0;
    wmask = '0;
    wbits = '0;
    rval = '0;
    if (rng.start_idx >= rng.end_idx) begin
      lo = int'(rng.end_idx);
      hi = int'(rng.start_idx);
    end else begin
      lo = int'(rng.start_idx);
      hi = int'(rng.end_idx);
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      if (i >= lo && i <= hi) begin
        if (rng.start_idx >= rng.end_idx) begin
          k = i - lo;
        end else begin
          k = hi - i;
        end
        wmask[i] = 1'b1; // [R8]
        wbits[i] = wval[k]; // [R8]
        rval[k] = cur[i]; // [R9]
      end
    end
  end
endmodule : mpd_range_unit

// File: hdl/mpd_core_dir.sv
/*
  One core's direction register with whole, single-bit and range writes.
  Assumes the bus slave decodes the strobes for this core.
*/
`timescale 1ns/1ps
module mpd_core_dir
  import mpd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic core_start,
  input wire logic wr_whole,
  input wire logic wr_masked,
  input wire logic [NUM_PINS-1:0] wmask,
  input wire logic [NUM_PINS-1:0] wbits,
  input wire logic [31:0] wdata,
  // State
  output logic [NUM_PINS-1:0] dir_q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= DIR_RESET;
    end else if (core_start) begin
      dir_q <= DIR_RESET; // [R3]
    end else if (wr_whole) begin
      dir_q <= wdata[NUM_PINS-1:0]; // [R1]
    end else if (wr_masked) begin
      dir_q <= (dir_q & ~wmask) | (wbits & wmask); // [R7]
    end
  end
endmodule : mpd_core_dir

// File: bench/mpd_pin_model.sv
/*
  Model of the circuitry on the port pins: each pin has a pull-down.
  Assumes the port drives a pin only where its output enable is high.
*/
`timescale 1ns/1ps
module mpd_pin_model
  import mpd_pkg::*;
(
  // Port side
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  // Wire level seen on the pins
  output logic [NUM_PINS-1:0] pin_level
);
  // An undriven pin settles to the pull-down level.
  assign pin_level = pin_oe & pin_out;
endmodule : mpd_pin_model

// File: bench/multicore_pin_direction_port_tb.sv
/*
  Self-checking bench for the multicore pin direction port.
  Assumes the APB slave answers with pready and the pin model on the pins.
*/
`timescale 1ns/1ps
module multicore_pin_direction_port_tb
  import mpd_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rv, v, pin_out, pin_oe, lvl;
  logic [3:0] pstrb, core_start, en;
  logic [31:0] dir [NUM_CORES];
  logic [31:0] outv [NUM_CORES];
  int fails, cmp_count, s, e, c, p;
  int cs[5] = '{5, 3, 7, 31, 0};
  int ce[5] = '{3, 5, 7, 0, 31};
  logic er;

  mpd_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_start(core_start), .pin_out(pin_out), .pin_oe(pin_oe));
  mpd_pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(lvl));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] eff(input logic [3:0] m, input bit use_out);
    eff = '0;
    for (int i = 0; i < NUM_CORES; i++) if (m[i]) eff |= dir[i] & (use_out ? outv[i] : '1);
  endfunction : eff

  function automatic logic [ADDR_W-1:0] base(input int k);
    return ADDR_W'(k * 16);
  endfunction : base

  initial begin
    {psel, penable, pwrite, paddr, pwdata, core_start} = '0;
    pstrb = 4'hf;
    presetn = 1'b0;
    fails = 0;
    cmp_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'hce77));
    for (int i = 0; i < NUM_CORES; i++) begin
      apb(1'b0, base(i), '0);
      chk("dir reset", rv, DIR_RESET);
      apb(1'b0, base(i) + OFF_UPPER_DIR, '0);
      chk("upper", rv, RESERVED_READ);
      dir[i] = $urandom;
      outv[i] = $urandom;
      apb(1'b1, base(i), dir[i]);
      apb(1'b1, base(i) + OFF_OUT_DATA, outv[i]);
      apb(1'b1, base(i) + OFF_UPPER_DIR, 32'hffff_ffff);
      apb(1'b0, base(i) + OFF_UPPER_DIR, '0);
      chk("upper wr", rv, RESERVED_READ);
    end
    @(negedge pclk);
    chk("oe off", pin_oe, '0);
    for (int t = 0; t < 6; t++) begin
      en = (t == 0) ? 4'hf : (t == 1) ? 4'h4 : 4'($urandom);
      apb(1'b1, OFF_CORE_EN, {28'h0, en});
      @(negedge pclk);
      chk("oe next", pin_oe, eff(en, 0));
      apb(1'b0, OFF_EFF_DIR, '0);
      chk("eff dir", rv, eff(en, 0));
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("pin oe", pin_oe, eff(en, 0));
      chk("pin out", pin_out, eff(en, 1));
      chk("pin level", lvl, eff(en, 1));
    end
    for (int t = 0; t < 12; t++) begin
      s = (t < 5) ? cs[t] : $urandom % 32;
      e = (t < 5) ? ce[t] : $urandom % 32;
      v = (t < 2) ? 32'h6 : $urandom;
      c = $urandom % NUM_CORES;
      apb(1'b1, OFF_RANGE_SEL, {19'h0, 5'(e), 3'h0, 5'(s)});
      apb(1'b1, base(c) + OFF_DIR_RANGE, v);
      for (int k = 0; k <= ((s > e) ? s - e : e - s); k++) begin
        p = (s > e) ? e + k : e - k;
        dir[c][p] = v[k];
      end
      apb(1'b0, base(c), '0);
      chk("range wr", rv, dir[c]);
      v = '0;
      for (int k = 0; k <= ((s > e) ? s - e : e - s); k++) v[k] = dir[c][(s > e) ? e + k : e - k];
      apb(1'b0, base(c) + OFF_DIR_RANGE, '0);
      chk("range rd", rv, v);
    end
    pstrb <= 4'h3;
    apb(1'b1, base(2), ~dir[2]);
    pstrb <= 4'hf;
    apb(1'b0, base(2), '0);
    chk("strobe refused", rv, dir[2]);
    apb(1'b1, OFF_EFF_DIR, 32'hffff_ffff);
    chk("eff wr err", {31'h0, er}, 32'h1);
    @(posedge pclk);
    core_start <= 4'h3;
    @(posedge pclk);
    core_start <= 4'h0;
    for (int i = 0; i < 2; i++) begin
      dir[i] = '0;
      apb(1'b0, base(i), '0);
      chk("start clr", rv, dir[i]);
    end
    apb(1'b0, 12'h200, '0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    give_verdict();
  end
endmodule : multicore_pin_direction_port_tb
